// [verilog/ipwc_ctrl.sv]
// interrupt controller end: flags, enables, priorities, vectors, wake
// assumes: peripherals pulse src_flag_set on clk_sys; ext pins are async
`timescale 1ns/100ps
module ipwc_ctrl #(
  parameter int NSRC = 8
) (
  ipwc_if.dev link,
  input wire logic [NSRC-1:0] src_flag_set,
  input wire logic [2:0] ext_irq_input,
  input wire logic vector_table_config_enable
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] main_ctrl;
  logic [NSRC-1:0] flags;
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] prios;
  logic [15:0] vt_base;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [1:0] arm_cnt;
  logic [2:0] ext_edge;
  logic [NSRC-1:0] set_all;
  logic [NSRC-1:0] req_high;
  logic [NSRC-1:0] req_low;
  logic [NSRC-1:0] prio_eff;
  logic any_high;
  logic any_low;
  logic [2:0] sel_src;
  logic [15:0] next_vector;
  logic [7:0] next_rdata;
  logic ple;
  logic [2:0] edge_sel;
  // declared ahead of every clocked process that uses it
  wire clk_sys_w = link.clk_sys;

  assign ple = main_ctrl[ipwc_pkg::MAIN_PLE];
  assign edge_sel = main_ctrl[ipwc_pkg::MAIN_EDGE_LSB +: ipwc_pkg::NUM_EXT];

  // lowest index among requesting sources
  function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ------------------------------------------------------------
  // external inputs
  // ------------------------------------------------------------
  // pin routing is done outside; all three ext pins reach here and are synchronised
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
    end else begin
      sync1 <= ext_irq_input;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // edges are ignored until the chain holds real pin history
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      arm_cnt <= 2'h0;
    end else if (arm_cnt != ipwc_pkg::SYNC_ARM_CYCLES) begin
      arm_cnt <= arm_cnt + 2'h1;
    end
  end

  // rising when the select bit is 1, falling when 0
  always_comb begin
    for (int i = 0; i < ipwc_pkg::NUM_EXT; i++) begin
      ext_edge[i] = (arm_cnt == ipwc_pkg::SYNC_ARM_CYCLES) &&
        (edge_sel[i] ? (sync2[i] && !sync3[i]) : (!sync2[i] && sync3[i]));
    end
  end

  // ext inputs occupy sources 0..2
  always_comb begin
    set_all = src_flag_set;
    set_all[ipwc_pkg::NUM_EXT-1:0] = src_flag_set[ipwc_pkg::NUM_EXT-1:0] | ext_edge;
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  // main control
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      main_ctrl <= ipwc_pkg::RST_MAIN;
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_MAIN) begin
      main_ctrl <= link.reg_wdata;
    end
  end

  // flags: write 1 to clear, a same-cycle event wins
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      flags <= '0;
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_FLAG) begin
      flags <= (flags & ~link.reg_wdata[NSRC-1:0]) | set_all;
    end else begin
      flags <= flags | set_all;
    end
  end

  // enables
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      enables <= '0;
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_ENABLE) begin
      enables <= link.reg_wdata[NSRC-1:0];
    end
  end

  // priorities come up all high
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      prios <= ipwc_pkg::RST_PRIO[NSRC-1:0];
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_PRIO) begin
      prios <= link.reg_wdata[NSRC-1:0];
    end
  end

  // vector table base
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      vt_base <= ipwc_pkg::RST_BASE;
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_BASE_LO) begin
      vt_base[7:0] <= link.reg_wdata;
    end else if (link.reg_wr && link.reg_addr == ipwc_pkg::REG_BASE_HI) begin
      vt_base[15:8] <= link.reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // priority resolution
  // ------------------------------------------------------------
  // with levels off every source counts as high under the high enable
  always_comb begin
    prio_eff = ple ? prios : '1;
    req_high = flags & enables & prio_eff &
      {NSRC{main_ctrl[ipwc_pkg::MAIN_GHE]}};
    req_low = flags & enables & ~prio_eff &
      {NSRC{main_ctrl[ipwc_pkg::MAIN_GLE]}};
    any_high = |req_high;
    any_low = |req_low;
    sel_src = any_high ? first_set(req_high) : first_set(req_low);
  end

  // vector choice; table order only counts with the table on
  always_comb begin
    if (vector_table_config_enable) begin
      next_vector = vt_base + {12'h000, sel_src, 1'b0};
    end else if (ple && !any_high) begin
      next_vector = ipwc_pkg::VEC_LEGACY_LOW;
    end else begin
      next_vector = ipwc_pkg::VEC_LEGACY_HIGH;
    end
  end

  // registered request to the core; a low request yields to a high one
  always_ff @(posedge clk_sys_w) begin
    if (link.sys_rst) begin
      link.irq_high <= 1'b0;
      link.irq_low <= 1'b0;
      link.irq_vector <= ipwc_pkg::VEC_LEGACY_HIGH;
      link.irq_src <= 3'h0;
    end else begin
      link.irq_high <= any_high;
      link.irq_low <= any_low && !any_high;
      link.irq_vector <= next_vector;
      link.irq_src <= sel_src;
    end
  end

  // ------------------------------------------------------------
  // wake and read back
  // ------------------------------------------------------------
  // no flop after the flag and enable registers, so flags already set still wake with every clock stopped;
  // the raw pin term covers an edge that cannot be clocked in sleep
  assign link.wake = |(flags & enables) |
    |(enables[ipwc_pkg::NUM_EXT-1:0] & ~(ext_irq_input ^ edge_sel));

  assign link.vt_mode = vector_table_config_enable;

  // read mux over register flops
  always_comb begin
    next_rdata = 8'h00;
    unique case (link.reg_addr)
      ipwc_pkg::REG_MAIN: next_rdata = main_ctrl;
      ipwc_pkg::REG_FLAG: next_rdata[NSRC-1:0] = flags;
      ipwc_pkg::REG_ENABLE: next_rdata[NSRC-1:0] = enables;
      ipwc_pkg::REG_PRIO: next_rdata[NSRC-1:0] = prios;
      ipwc_pkg::REG_BASE_LO: next_rdata = vt_base[7:0];
      ipwc_pkg::REG_BASE_HI: next_rdata = vt_base[15:8];
      ipwc_pkg::REG_STATUS: next_rdata = {link.irq_high, link.irq_low, 3'h0, link.irq_src};
      default: next_rdata = 8'h00;
    endcase
  end
  assign link.reg_rdata = next_rdata;
endmodule

// [verilog/ipwc_pkg.sv]
// package of the interrupt priority and wake controller
// assumes: both ends and the bench refer to it by scoped names only
package ipwc_pkg;
  // ------------------------------------------------------------
  // device register map (8-bit registers, 4-bit index)
  // ------------------------------------------------------------
  localparam int AW = 4;
  localparam int DW = 8;
  localparam logic [3:0] REG_MAIN = 4'h0; // main_interrupt_control
  localparam logic [3:0] REG_FLAG = 4'h1; // source_flag_regs, write 1 to clear
  localparam logic [3:0] REG_ENABLE = 4'h2; // source_enable_regs
  localparam logic [3:0] REG_PRIO = 4'h3; // source_priority_regs
  localparam logic [3:0] REG_BASE_LO = 4'h4; // vector_table_base low byte
  localparam logic [3:0] REG_BASE_HI = 4'h5; // vector_table_base high byte
  localparam logic [3:0] REG_STATUS = 4'h6; // read only
  // main_interrupt_control fields
  localparam int MAIN_GHE = 7; // global_high_enable
  localparam int MAIN_GLE = 6; // global_low_enable
  localparam int MAIN_PLE = 5; // priority_levels_enable
  localparam int MAIN_EDGE_LSB = 0; // ext_edge_select, three bits
  localparam logic [7:0] MAIN_GIE_MASK = 8'hC0;
  // reset values
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_PRIO = 8'hFF; // all sources high priority
  localparam logic [15:0] RST_BASE = 16'h0008;
  // fixed vectors when the vector table is off
  localparam logic [15:0] VEC_LEGACY_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LEGACY_LOW = 16'h0018;
  localparam int NUM_EXT = 3;
  localparam logic [1:0] SYNC_ARM_CYCLES = 2'h3;
  // ------------------------------------------------------------
  // cpu-side AHB-Lite word offsets
  // ------------------------------------------------------------
  localparam logic [7:0] HOST_CMD = 8'h00;
  localparam logic [7:0] HOST_STATUS = 8'h04;
  localparam logic [7:0] HOST_ACK = 8'h08;
  localparam logic [7:0] HOST_RDATA = 8'h0C;
  localparam int CMD_READ_BIT = 12;
endpackage

// [verilog/ipwc_if.sv]
// link between the interrupt controller and the cpu-side end
// assumes: one clock and one synchronous reset shared by both ends
`timescale 1ns/100ps
interface ipwc_if (
  input wire logic clk_sys,
  input wire logic sys_rst
);
  logic reg_wr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq_high;
  logic irq_low;
  logic [15:0] irq_vector;
  logic [2:0] irq_src;
  logic vt_mode;
  logic wake;

  modport dev (
    input clk_sys, sys_rst, reg_wr, reg_addr, reg_wdata,
    output reg_rdata, irq_high, irq_low, irq_vector, irq_src, vt_mode, wake
  );
  modport cpu (
    input clk_sys, sys_rst, reg_rdata, irq_high, irq_low, irq_vector, irq_src,
    input vt_mode, wake,
    output reg_wr, reg_addr, reg_wdata
  );
endinterface

// [verilog/ipwc_cpu.sv]
// cpu-side end: AHB-Lite slave that programs the controller in order
// assumes: single word transfers, a single slave, OKAY responses only
`timescale 1ns/100ps
module ipwc_cpu (
  ipwc_if.cpu link,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  typedef enum logic [2:0] {
    IPWC_IDLE = 3'b001,
    IPWC_CLR = 3'b010,
    IPWC_SEND = 3'b100
  } ipwc_state_t;

  ipwc_state_t state;
  logic dp_wr;
  logic dp_rd;
  logic [7:0] dp_addr;
  logic cmd_rd;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [7:0] clr_mask;
  logic [7:0] rdata;
  logic err;
  logic ple_seen;
  logic base_seen;
  logic [7:0] en_shadow;
  logic take;
  logic is_cmd;
  logic is_ack;
  logic [3:0] w_addr;
  logic [7:0] w_data;
  wire clk_sys = link.clk_sys;

  assign w_addr = hwdata[11:8];
  assign w_data = hwdata[7:0];

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  // address phase capture
  always_ff @(posedge clk_sys) begin
    if (link.sys_rst) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr <= hsel && htrans[1] && hwrite;
      dp_rd <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr;
    end
  end

  // a command waits in its data phase while the last one is in flight
  assign hreadyout = !(dp_wr && state != IPWC_IDLE);
  assign hresp = 1'b0;
  assign take = dp_wr && state == IPWC_IDLE;
  assign is_cmd = take && dp_addr == ipwc_pkg::HOST_CMD;
  assign is_ack = take && dp_addr == ipwc_pkg::HOST_ACK;

  // read data, unmapped words read zero
  always_comb begin
    hrdata = 32'h00000000;
    if (dp_rd && dp_addr == ipwc_pkg::HOST_STATUS) begin
      hrdata = {link.irq_vector, 5'h00, link.irq_src, 3'h0, link.wake,
        link.irq_low, link.irq_high, err, state != IPWC_IDLE};
    end else if (dp_rd && dp_addr == ipwc_pkg::HOST_RDATA) begin
      hrdata = {24'h000000, rdata};
    end
  end

  // ------------------------------------------------------------
  // ordering engine
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (link.sys_rst) begin
      state <= IPWC_IDLE;
      cmd_rd <= 1'b0;
      cmd_addr <= 4'h0;
      cmd_data <= 8'h00;
      clr_mask <= 8'h00;
      err <= 1'b0;
    end else begin
      unique case (state)
        IPWC_IDLE: begin
          if (is_ack) begin
            cmd_rd <= 1'b0;
            cmd_addr <= ipwc_pkg::REG_FLAG;
            cmd_data <= 8'(8'h01 << hwdata[2:0]);
            state <= IPWC_SEND;
          end else if (is_cmd) begin
            cmd_rd <= hwdata[ipwc_pkg::CMD_READ_BIT];
            cmd_addr <= w_addr;
            cmd_data <= w_data;
            clr_mask <= w_data & ~en_shadow;
            err <= 1'b0;
            if (!hwdata[ipwc_pkg::CMD_READ_BIT] && w_addr == ipwc_pkg::REG_PRIO &&
                !ple_seen) begin
              err <= 1'b1;
            end else if (!hwdata[ipwc_pkg::CMD_READ_BIT] && w_addr == ipwc_pkg::REG_MAIN &&
                link.vt_mode && !base_seen && |(w_data & ipwc_pkg::MAIN_GIE_MASK)) begin
              err <= 1'b1;
            end else if (!hwdata[ipwc_pkg::CMD_READ_BIT] &&
                w_addr == ipwc_pkg::REG_ENABLE && |(w_data & ~en_shadow)) begin
              state <= IPWC_CLR;
            end else begin
              state <= IPWC_SEND;
            end
          end
        end
        IPWC_CLR: begin
          state <= IPWC_SEND;
        end
        IPWC_SEND: begin
          state <= IPWC_IDLE;
        end
        default: begin
          state <= IPWC_IDLE;
        end
      endcase
    end
  end

  // link drive: flag clear first, then the command itself
  assign link.reg_wr = state == IPWC_CLR || (state == IPWC_SEND && !cmd_rd);
  assign link.reg_addr = state == IPWC_CLR ? ipwc_pkg::REG_FLAG : cmd_addr;
  assign link.reg_wdata = state == IPWC_CLR ? clr_mask : cmd_data;

  // shadows of what the controller has been told
  always_ff @(posedge clk_sys) begin
    if (link.sys_rst) begin
      ple_seen <= 1'b0;
      base_seen <= 1'b0;
      en_shadow <= 8'h00;
      rdata <= 8'h00;
    end else if (state == IPWC_SEND) begin
      if (cmd_rd) begin
        rdata <= link.reg_rdata;
      end else if (cmd_addr == ipwc_pkg::REG_MAIN) begin
        ple_seen <= cmd_data[ipwc_pkg::MAIN_PLE];
      end else if (cmd_addr == ipwc_pkg::REG_ENABLE) begin
        en_shadow <= cmd_data;
      end else if (cmd_addr == ipwc_pkg::REG_BASE_LO || cmd_addr == ipwc_pkg::REG_BASE_HI) begin
        base_seen <= 1'b1;
      end
    end
  end
endmodule

// [testbench/ipwc_monitor.sv]
// checker on the link between the controller end and the cpu end
// assumes: placed beside the interface, one clock, synchronous reset
`timescale 1ns/100ps
module ipwc_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic [15:0] irq_vector,
  input wire logic [2:0] irq_src,
  input wire logic vt_mode,
  input wire logic wake
);
  // ----------------------------------------------------------
  // helper state
  // ----------------------------------------------------------
  logic prio_written;

  // remembers a priority write, the reset value is only owed before it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prio_written <= 1'b0;
    end else if (reg_wr && reg_addr == ipwc_pkg::REG_PRIO) begin
      prio_written <= 1'b1;
    end
  end

  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence enable_wr;
    reg_wr && reg_addr == ipwc_pkg::REG_ENABLE;
  endsequence

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  a_one_level: assert property (irq_low |-> !irq_high)
    else $error("low request shown beside a high one");
  a_reset_vals: assert property ($past(sys_rst) |-> !irq_high && !irq_low &&
    irq_vector == ipwc_pkg::RST_BASE) else $error("request outputs wrong after reset");
  a_prio_reset: assert property (!prio_written && reg_addr == ipwc_pkg::REG_PRIO |->
    reg_rdata == 8'hFF) else $error("priorities not all high after reset");
  // irq reflects last cycle state, so a write in that cycle excuses it
  a_irq_wakes: assert property ((irq_high || irq_low) && !$past(reg_wr) &&
    !$past(sys_rst) |-> wake) else $error("request without wake");
  a_status_map: assert property (reg_addr == ipwc_pkg::REG_STATUS |->
    reg_rdata == {irq_high, irq_low, 3'h0, irq_src}) else $error("status byte wrong");
  a_unmapped_zero: assert property (reg_addr > ipwc_pkg::REG_STATUS |->
    reg_rdata == 8'h00) else $error("unmapped index reads nonzero");
  a_enable_kept: assert property (enable_wr ##1 reg_addr == ipwc_pkg::REG_ENABLE |->
    reg_rdata == $past(reg_wdata)) else $error("enable byte not stored");
  a_legacy_high: assert property (!vt_mode && $past(vt_mode) == 1'b0 && irq_high |->
    irq_vector == ipwc_pkg::VEC_LEGACY_HIGH) else $error("fixed high vector wrong");
  a_legacy_low: assert property (!vt_mode && $past(vt_mode) == 1'b0 && irq_low |->
    irq_vector == ipwc_pkg::VEC_LEGACY_LOW) else $error("fixed low vector wrong");
endmodule

// [testbench/ipwc_tb.sv]
// self-checking bench: both ends joined, software side over AHB-Lite
// assumes: the cpu end is the only slave, its hreadyout is hready
`timescale 1ns/100ps
module ipwc_tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] src_set = 8'h00;
  logic [2:0] pins = 3'h0;
  logic vt = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] st;
  logic [7:0] b;
  localparam logic [31:0] M_IRQ = 32'hFFFF071C;
  localparam logic [31:0] M_ERR = 32'h00000002;

  ipwc_if u_ipwc_if (.clk_sys(clk_sys), .sys_rst(sys_rst));
  ipwc_ctrl u_ipwc_ctrl (.link(u_ipwc_if), .src_flag_set(src_set), .ext_irq_input(pins),
    .vector_table_config_enable(vt));
  ipwc_cpu u_ipwc_cpu (.link(u_ipwc_if), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  ipwc_monitor u_ipwc_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .reg_wr(u_ipwc_if.reg_wr), .reg_addr(u_ipwc_if.reg_addr),
    .reg_wdata(u_ipwc_if.reg_wdata), .reg_rdata(u_ipwc_if.reg_rdata),
    .irq_high(u_ipwc_if.irq_high), .irq_low(u_ipwc_if.irq_low),
    .irq_vector(u_ipwc_if.irq_vector), .irq_src(u_ipwc_if.irq_src),
    .vt_mode(u_ipwc_if.vt_mode), .wake(u_ipwc_if.wake));

  // 20 MHz clock and a cycle ceiling well above the test length
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      $display("BAD %0t timeout", $time);
      final_report();
    end
  end

  // ----------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------
  // settled values at the falling edge equal what the next rising edge sees
  task automatic wait_rdy(output logic [31:0] d);
    @(negedge clk_sys);
    while (hreadyout !== 1'b1) @(negedge clk_sys);
    d = hrdata;
    // the slave may only ever answer okay
    if (hresp !== 1'b0) begin
      num_errors++;
      $display("BAD %0t error response", $time);
    end
    @(posedge clk_sys);
  endtask
  task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                          output logic [31:0] rd);
    logic [31:0] dummy;
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    wait_rdy(dummy);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask
  task automatic get_stat();
    ahb_xfer(ipwc_pkg::HOST_STATUS, 1'b0, 32'h0, st);
  endtask
  // the next command stalls anyway; polling keeps reads of rdata honest
  task automatic wait_idle();
    get_stat();
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++) get_stat();
  endtask
  task automatic dev_wr(input logic [3:0] idx, input logic [7:0] d);
    ahb_xfer(ipwc_pkg::HOST_CMD, 1'b1, {20'h0, idx, d}, st);
    wait_idle();
  endtask
  task automatic dev_rd(input logic [3:0] idx);
    ahb_xfer(ipwc_pkg::HOST_CMD, 1'b1, {19'h0, 1'b1, idx, 8'h00}, st);
    wait_idle();
    ahb_xfer(ipwc_pkg::HOST_RDATA, 1'b0, 32'h0, st);
    b = st[7:0];
  endtask
  task automatic ack(input logic [2:0] s);
    ahb_xfer(ipwc_pkg::HOST_ACK, 1'b1, {29'h0, s}, st);
    repeat (3) @(posedge clk_sys);
  endtask
  // one-cycle flag pulse; requests follow two cycles later
  task automatic pulse(input int s);
    @(posedge clk_sys);
    src_set <= 8'h01 << s;
    @(posedge clk_sys);
    src_set <= 8'h00;
    repeat (3) @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------
  // compare tasks and report
  // ----------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_stat(input logic [31:0] mask, input logic [31:0] exp);
    get_stat();
    checks_done++;
    if ((st & mask) !== exp) begin
      num_errors++;
      $display("BAD %0t status %h expected %h", $time, st & mask, exp);
    end
  endtask
  function automatic logic [31:0] sx(logic [15:0] v, logic [2:0] s, logic [2:0] wlh);
    return {v, 5'h0, s, 3'h0, wlh, 2'h0};
  endfunction
  task automatic test_done(input string name);
    $display("test %s done, errors so far %0d", name, num_errors);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    dev_rd(ipwc_pkg::REG_PRIO);
    chk_byte(b, 8'hFF);
    dev_wr(ipwc_pkg::REG_PRIO, 8'h00);
    chk_stat(M_ERR, 32'h2);
    dev_rd(ipwc_pkg::REG_PRIO);
    chk_byte(b, 8'hFF);
    dev_rd(4'hA);
    chk_byte(b, 8'h00);
    test_done("reset_refuse");
    dev_wr(ipwc_pkg::REG_ENABLE, 8'h20);
    pulse(5);
    chk_stat(32'h1C, sx(16'h0, 3'h0, 3'h4));
    dev_wr(ipwc_pkg::REG_MAIN, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk_stat(M_IRQ, sx(16'h0008, 3'h5, 3'h5));
    dev_rd(ipwc_pkg::REG_STATUS);
    chk_byte(b, 8'h85);
    ack(3'h5);
    chk_stat(32'h1C, 32'h0);
    test_done("single_level");
    dev_wr(ipwc_pkg::REG_MAIN, 8'hE0);
    dev_wr(ipwc_pkg::REG_PRIO, 8'hDF);
    dev_wr(ipwc_pkg::REG_ENABLE, 8'h60);
    pulse(5);
    chk_stat(M_IRQ, sx(16'h0018, 3'h5, 3'h6));
    pulse(6);
    chk_stat(M_IRQ, sx(16'h0008, 3'h6, 3'h5));
    ack(3'h6);
    ack(3'h5);
    chk_stat(32'h1C, 32'h0);
    dev_wr(ipwc_pkg::REG_PRIO, 8'hFF);
    dev_wr(ipwc_pkg::REG_MAIN, 8'h00);
    test_done("two_levels");
    dev_wr(ipwc_pkg::REG_ENABLE, 8'h07);
    for (int i = 0; i < 3; i++) begin
      for (int e = 0; e < 2; e++) begin
        dev_wr(ipwc_pkg::REG_MAIN, 8'h80 | (8'(e) << i));
        pins[i] <= e[0];
        repeat (5) @(posedge clk_sys);
        ack(3'(i));
        pins[i] <= ~e[0];
        repeat (5) @(posedge clk_sys);
        dev_rd(ipwc_pkg::REG_FLAG);
        chk_byte(b & (8'h01 << i), 8'h00);
        pins[i] <= e[0];
        repeat (5) @(posedge clk_sys);
        chk_stat(M_IRQ, sx(16'h0008, 3'(i), 3'h5));
        pins[i] <= ~e[0];
        repeat (5) @(posedge clk_sys);
        dev_rd(ipwc_pkg::REG_FLAG);
        chk_byte(b & (8'h01 << i), 8'h01 << i);
        chk_stat(32'h10, 32'h10);
        ack(3'(i));
      end
    end
    test_done("ext_edges");
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    vt <= 1'b1;
    dev_wr(ipwc_pkg::REG_MAIN, 8'h80);
    chk_stat(M_ERR, 32'h2);
    dev_rd(ipwc_pkg::REG_MAIN);
    chk_byte(b, 8'h00);
    dev_wr(ipwc_pkg::REG_BASE_LO, 8'h40);
    dev_wr(ipwc_pkg::REG_BASE_HI, 8'h12);
    dev_wr(ipwc_pkg::REG_MAIN, 8'h80);
    pulse(4);
    chk_stat(32'h1C, 32'h0);
    dev_wr(ipwc_pkg::REG_ENABLE, 8'h10);
    chk_stat(32'h1C, 32'h0);
    pulse(4);
    chk_stat(M_IRQ, sx(16'h1248, 3'h4, 3'h5));
    ack(3'h4);
    vt <= 1'b0;
    test_done("vector_table");
    final_report();
  end
endmodule
